// ==== design/dssr_readout.sv ====
// serial readout of decimated 24-bit samples: fifo, link shifter and top
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module dssr_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
   localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic rdy;
      logic vld;
   } dssr_fifo_st_t;

   dssr_fifo_st_t q;
   dssr_fifo_st_t d;
   logic push;
   logic pop;

   assign push = in_valid & q.rdy;
   assign pop = out_ready & q.vld;
   assign in_ready = q.rdy;
   assign out_valid = q.vld;
   assign out_data = q.mem[q.rd];

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wr] = in_data;
         d.wr = (q.wr == PTR_LAST) ? '0 : q.wr + 1'b1;
      end
      if (pop) begin
         d.rd = (q.rd == PTR_LAST) ? '0 : q.rd + 1'b1;
      end
      case ({push, pop})
         2'b10: d.cnt = q.cnt + 1'b1;
         2'b01: d.cnt = q.cnt - 1'b1;
         default: d.cnt = q.cnt;
      endcase
      // ready and valid registered so the top sees flop outputs
      d.rdy = (d.cnt != CNT_FULL);
      d.vld = (d.cnt != '0);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= '{mem: '0, wr: '0, rd: '0, cnt: '0, rdy: 1'b1, vld: 1'b0};
      end else begin
         q <= d;
      end
   end

   default clocking fifo_cb @(posedge clk);
   endclocking
   default disable iff (reset);

   property p_fifo_no_overflow;
      !q.rdy |-> (q.cnt == CNT_FULL) && !push;
   endproperty
   a_fifo_no_overflow: assert property (p_fifo_no_overflow)
      else $error("fifo accepted a word while full");

   property p_fifo_keeps_count;
      (push && !pop) |=> (q.cnt == $past(q.cnt) + 1'b1) && q.vld;
   endproperty
   a_fifo_keeps_count: assert property (p_fifo_keeps_count)
      else $error("fifo count did not follow a push");
endmodule

////////////////////////////////////////////////////////////////////////////////
module dssr_link
   import dssr_pkg::*;
(
   input wire logic shift_clk,
   input wire logic link_rst,
   input wire logic chain_in,
   input wire logic [WORD_W-1:0] word,
   output logic started,
   output logic out_bit
);
   typedef struct packed {
      logic [BIT_W-1:0] cnt;
      logic started;
      logic out_bit;
      logic [WORD_W-1:0] chain_sr;
   } dssr_link_st_t;

   dssr_link_st_t q;
   dssr_link_st_t d;
   logic [BIT_W-1:0] cnt_nx;

   assign started = q.started;
   assign out_bit = q.out_bit;

   always_comb begin
      d = q;
      cnt_nx = (q.cnt == CHAIN_BIT) ? q.cnt : q.cnt + 5'h01;
      d.cnt = cnt_nx;
      d.started = 1'b1;
      d.chain_sr = {q.chain_sr[WORD_W-2:0], chain_in};
      // own bits first, then upstream bits delayed by one word
      if (cnt_nx <= LAST_OWN_BIT) begin
         d.out_bit = word[LAST_OWN_BIT - cnt_nx];
      end else begin
         d.out_bit = q.chain_sr[WORD_W-2];
      end
   end

   // word is held stable by the master side while a frame is open
   always_ff @(negedge shift_clk or posedge link_rst) begin
      if (link_rst) begin
         q <= '{cnt: BIT_CNT_RST, started: 1'b0, out_bit: 1'b0, chain_sr: '0};
      end else begin
         q <= d;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module dssr_readout
   import dssr_pkg::*;
#(
   parameter int DECIM_N = DECIM_N_DEFAULT
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic shift_clk,
   input wire logic sync_powerdown_n,
   input wire logic select_n,
   input wire logic chain_in,
   input wire logic [WORD_W-1:0] sample_data,
   input wire logic sample_valid,
   output logic sample_ready,
   output logic word_ready_n,
   output logic serial_out,
   output logic serial_oe
);
   localparam int PER_CYC = PERIOD_MULT * DECIM_N;
   localparam int SETTLE_CYC = SETTLE_MULT * DECIM_N + SETTLE_ADD;
   localparam logic [PER_W-1:0] PER_LAST = PER_W'(PER_CYC - 1);
   localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYC);

   typedef struct packed {
      logic [1:0] sel_m;
      logic [1:0] pd_m;
      logic [1:0] start_m;
      logic [1:0] bit_m;
      logic [PER_W-1:0] per_cnt;
      logic [SETTLE_W-1:0] settle_cnt;
      logic loaded;
      logic [WORD_W-1:0] word;
      logic wr_n;
      logic sout;
      logic soe;
   } dssr_top_st_t;

   localparam dssr_top_st_t ST_RST = '{
      sel_m: SYNC_RST_HIGH, pd_m: SYNC_RST_LOW, start_m: SYNC_RST_LOW,
      bit_m: SYNC_RST_LOW, per_cnt: '0, settle_cnt: SETTLE_LOAD, loaded: 1'b0,
      word: '0, wr_n: 1'b1, sout: 1'b0, soe: 1'b0};

   dssr_top_st_t q;
   dssr_top_st_t d;
   logic sel_s;
   logic pd_s;
   logic start_s;
   logic bit_s;
   logic fifo_valid;
   logic fifo_pop;
   logic [WORD_W-1:0] fifo_data;
   logic link_rst;
   logic link_started;
   logic link_bit;

   ////////////////////////////////////////////////////////////////////////////
   dssr_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .reset(reset),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .in_data(sample_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // frame closed whenever select is high or the strobe is high
   assign link_rst = reset | select_n | q.wr_n;

   dssr_link u_link (
      .shift_clk(shift_clk),
      .link_rst(link_rst),
      .chain_in(chain_in),
      .word(q.word),
      .started(link_started),
      .out_bit(link_bit)
   );

   ////////////////////////////////////////////////////////////////////////////
   assign sel_s = q.sel_m[1];
   assign pd_s = q.pd_m[1];
   assign start_s = q.start_m[1];
   assign bit_s = q.bit_m[1];

   always_comb begin
      d = q;
      fifo_pop = 1'b0;
      d.sel_m = {q.sel_m[0], select_n};
      d.pd_m = {q.pd_m[0], sync_powerdown_n};
      d.start_m = {q.start_m[0], link_started};
      d.bit_m = {q.bit_m[0], link_bit};
      if (!pd_s) begin
         // halted: strobe parked high, settling reloaded
         d.wr_n = 1'b1;
         d.per_cnt = '0;
         d.loaded = 1'b0;
         d.settle_cnt = SETTLE_LOAD;
      end else if (q.settle_cnt != '0) begin
         d.settle_cnt = q.settle_cnt - 1'b1;
         d.wr_n = 1'b1;
      end else begin
         d.per_cnt = (q.per_cnt == PER_LAST) ? '0 : q.per_cnt + 1'b1;
         if (q.per_cnt == '0) begin
            d.wr_n = 1'b1;
            d.loaded = fifo_valid;
            if (fifo_valid) begin
               fifo_pop = 1'b1;
               d.word = fifo_data;
            end
         end else if (q.per_cnt == STROBE_HIGH_CYC && q.loaded) begin
            d.wr_n = 1'b0;
         end
      end
      d.soe = !sel_s;
      if (q.wr_n) begin
         d.sout = d.wr_n ? 1'b0 : q.word[WORD_W-1];
      end else if (start_s) begin
         d.sout = bit_s;
      end else begin
         d.sout = q.word[WORD_W-1];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   assign word_ready_n = q.wr_n;
   assign serial_out = q.sout;
   assign serial_oe = q.soe;

   ////////////////////////////////////////////////////////////////////////////
   default clocking top_cb @(posedge clk);
   endclocking
   default disable iff (reset);

   property p_strobe_period;
      $rose(word_ready_n) && pd_s |-> ##PER_CYC word_ready_n;
   endproperty
   a_strobe_period: assert property (p_strobe_period)
      else $error("strobe did not repeat at the decimated period");

   property p_strobe_pulse;
      $rose(word_ready_n) && pd_s ##1 pd_s |-> word_ready_n;
   endproperty
   a_strobe_pulse: assert property (p_strobe_pulse)
      else $error("strobe high pulse shorter than two cycles");

   property p_settle_holds;
      (q.settle_cnt != '0) |-> word_ready_n;
   endproperty
   a_settle_holds: assert property (p_settle_holds)
      else $error("word ready fell before filter settled");

   property p_float_when_deselected;
      select_n [*4] |-> !serial_oe;
   endproperty
   a_float_when_deselected: assert property (p_float_when_deselected)
      else $error("serial output driven while select high");

   property p_drive_after_select;
      $fell(select_n) ##1 !select_n [*3] |-> serial_oe;
   endproperty
   a_drive_after_select: assert property (p_drive_after_select)
      else $error("serial output not driven after select fell");

   property p_release_after_select;
      $rose(select_n) |-> ##[1:3] !serial_oe;
   endproperty
   a_release_after_select: assert property (p_release_after_select)
      else $error("serial output not released after select rose");

   property p_msb_first;
      $fell(word_ready_n) |-> serial_out == q.word[WORD_W-1];
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("msb not presented at word ready fall");

   property p_bit_follows_link;
      (start_s && !word_ready_n) |=> serial_out == $past(bit_s);
   endproperty
   a_bit_follows_link: assert property (p_bit_follows_link)
      else $error("serial output does not follow shifted bit");

   property p_sync_forces_high;
      $fell(sync_powerdown_n) |-> ##[1:4] word_ready_n;
   endproperty
   a_sync_forces_high: assert property (p_sync_forces_high)
      else $error("word ready not high after sync fell");

   property p_powerdown_quiet;
      !pd_s |=> word_ready_n && !fifo_pop;
   endproperty
   a_powerdown_quiet: assert property (p_powerdown_quiet)
      else $error("strobe activity during power-down");

   property p_resume_settles;
      $rose(pd_s) |-> word_ready_n [*8];
   endproperty
   a_resume_settles: assert property (p_resume_settles)
      else $error("word ready fell right after resume");

   property p_word_loaded;
      fifo_pop |=> q.word == $past(fifo_data);
   endproperty
   a_word_loaded: assert property (p_word_loaded)
      else $error("popped sample not captured as output word");
endmodule

// ==== design/dssr_pkg.sv ====
// constants shared by the decimated sample serial readout block
package dssr_pkg;
   localparam int WORD_W = 24;
   localparam int FIFO_DEPTH = 8;
   localparam int PERIOD_MULT = 8;
   localparam int SETTLE_MULT = 592;
   localparam int SETTLE_ADD = 2;
   localparam int DECIM_N_DEFAULT = 4;
   localparam int PER_W = 6;
   localparam int SETTLE_W = 12;
   localparam int BIT_W = 5;
   localparam logic [PER_W-1:0] STROBE_HIGH_CYC = 6'h02;
   localparam logic [BIT_W-1:0] BIT_CNT_RST = 5'h00;
   localparam logic [BIT_W-1:0] LAST_OWN_BIT = 5'h17;
   localparam logic [BIT_W-1:0] CHAIN_BIT = 5'h18;
   localparam logic [1:0] SYNC_RST_HIGH = 2'h3;
   localparam logic [1:0] SYNC_RST_LOW = 2'h0;
endpackage

// ==== verif/dssr_host.sv ====
// host model: selects the readout block and clocks serial bits in
`timescale 1ns/10ps

module dssr_host (
   input wire logic word_ready_n,
   input wire logic serial_out,
   input wire logic serial_oe,
   output logic select_n,
   output logic shift_clk,
   output logic chain_in
);
   logic last_q = 1'b0;
   logic line;

   // released line shows the inverse of the last driven value
   always @(serial_out or serial_oe) if (serial_oe) last_q = serial_out;
   assign line = serial_oe ? serial_out : ~last_q;

   initial begin
      select_n = 1'b1;
      shift_clk = 1'b1;
      chain_in = 1'b0;
   end

   task automatic hold_select(input logic v);
      select_n = v;
   endtask

   // shift clock runs only inside a frame, 125 ns period
   task automatic read_bits(output logic [3:0] bits, output logic ok);
      bits = 4'h0;
      ok = 1'b0;
      if (word_ready_n !== 1'b0) return;
      select_n = 1'b0;
      #100;
      for (int k = 0; k < 4; k++) begin
         bits = {bits[2:0], line};
         if (k < 3) begin
            shift_clk = 1'b0;
            #62.5;
            shift_clk = 1'b1;
            chain_in = ~chain_in;
            #62.5;
         end
      end
      ok = (word_ready_n === 1'b0);
      select_n = 1'b1;
   endtask
endmodule

// ==== verif/dssr_readout_tb.sv ====
// self-checking bench for the decimated sample serial readout
`timescale 1ns/10ps

module dssr_readout_tb;
   import dssr_pkg::*;
   localparam int N = 4;
   localparam int PER = PERIOD_MULT * N;
   localparam int SETTLE = SETTLE_MULT * N + SETTLE_ADD;
   logic clk, reset, shift_clk, sync_powerdown_n, select_n, chain_in;
   logic [WORD_W-1:0] sample_data;
   logic sample_valid, sample_ready, word_ready_n, serial_out, serial_oe;
   int n_mismatch = 0;
   int checked = 0;

   dssr_readout #(.DECIM_N(N)) dssr_readout_inst (.clk(clk), .reset(reset),
      .shift_clk(shift_clk), .sync_powerdown_n(sync_powerdown_n), .select_n(select_n),
      .chain_in(chain_in), .sample_data(sample_data), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .word_ready_n(word_ready_n), .serial_out(serial_out),
      .serial_oe(serial_oe));
   dssr_host dssr_host_inst (.word_ready_n(word_ready_n), .serial_out(serial_out),
      .serial_oe(serial_oe), .select_n(select_n), .shift_clk(shift_clk),
      .chain_in(chain_in));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (exp !== got) begin
         n_mismatch++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic wait_wr(input logic lvl, input int max, output int n);
      n = 0;
      while (word_ready_n !== lvl) begin
         @(negedge clk);
         n++;
         if (n > max) begin
            check("wait timeout", 0, 1);
            conclude();
         end
      end
   endtask

   function automatic logic [WORD_W-1:0] wd(input int i);
      return {4'(i * 5 + 3), 20'h5_A5A5};
   endfunction

   task automatic t_fill(input int base);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         sample_data = wd(base + i);
         sample_valid = 1'b1;
         @(negedge clk);
      end
      sample_data = wd(99);
      @(negedge clk);
      check("sample_ready full", 0, sample_ready);
      sample_valid = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_settle();
      int n;
      t_fill(0);
      wait_wr(1'b0, SETTLE + PER + 20, n);
      n = n + FIFO_DEPTH + 1;
      check("settle", 1, n >= SETTLE && n <= SETTLE + PER + 8);
   endtask

   task automatic t_read();
      int n;
      longint t_prev;
      logic [3:0] bits;
      logic ok;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         wait_wr(1'b0, PER + 8, n);
         check("oe before select", 0, serial_oe);
         dssr_host_inst.read_bits(bits, ok);
         check("top bits", wd(i) >> 20, bits);
         check("read window", 1, ok);
         repeat (4) @(negedge clk);
         check("oe after select", 0, serial_oe);
         wait_wr(1'b1, PER, n);
         if (i > 0) check("period", PER * 20, 32'($time - t_prev));
         t_prev = $time;
      end
   endtask

   task automatic t_sync();
      int n;
      sample_data = wd(8);
      sample_valid = 1'b1;
      @(negedge clk);
      sample_valid = 1'b0;
      wait_wr(1'b0, 2 * PER + 8, n);
      sync_powerdown_n = 1'b0;
      wait_wr(1'b1, 4, n);
      t_fill(10);
      n = 0;
      repeat (3 * PER) begin
         @(negedge clk);
         if (word_ready_n !== 1'b1) n++;
      end
      check("strobe while down", 0, n);
      sync_powerdown_n = 1'b1;
      wait_wr(1'b0, SETTLE + PER + 20, n);
      check("resume", 1, n >= SETTLE && n <= SETTLE + PER + 8);
   endtask

   task automatic t_cs_low();
      int n;
      reset = 1'b1;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      dssr_host_inst.hold_select(1'b0);
      t_fill(20);
      for (int i = 0; i < 2; i++) begin
         wait_wr(1'b0, SETTLE + PER + 20, n);
         check("msb at fall", {1'b1, 1'(wd(20 + i) >> 23)}, {serial_oe, serial_out});
         repeat (PER - 4) @(negedge clk);
         check("msb held", {1'b0, 1'(wd(20 + i) >> 23)}, {word_ready_n, serial_out});
         wait_wr(1'b1, 8, n);
      end
      dssr_host_inst.hold_select(1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      reset = 1'b1;
      sync_powerdown_n = 1'b1;
      sample_valid = 1'b0;
      sample_data = '0;
      repeat (3) @(negedge clk);
      check("reset outputs", 4'h9, {word_ready_n, serial_oe, serial_out, sample_ready});
      reset = 1'b0;
      t_settle();
      t_read();
      t_sync();
      t_cs_low();
      conclude();
   end
endmodule
